// [rtl/pspb_map.vh]
// register map, field positions, reset values and mode codes
`ifndef PSPB_MAP_VH
`define PSPB_MAP_VH

`define PSPB_AW             3
`define PSPB_OFS_CONTROL    3'h0
`define PSPB_OFS_MODE       3'h1
`define PSPB_OFS_OUT_ONE    3'h2
`define PSPB_OFS_OUT_TWO    3'h3
`define PSPB_OFS_IN_ONE     3'h4
`define PSPB_OFS_IN_TWO     3'h5
`define PSPB_OFS_STATUS     3'h6
`define PSPB_OFS_IRQ_FLAG   3'h7

`define PSPB_CTL_ENABLE     15
`define PSPB_MODE_IRQM_HI   14
`define PSPB_MODE_IRQM_LO   13
`define PSPB_MODE_INCM_HI   12
`define PSPB_MODE_INCM_LO   11
`define PSPB_MODE_PORT_HI   9
`define PSPB_MODE_PORT_LO   8

`define PSPB_ST_ALL_FULL    15
`define PSPB_ST_OVERFLOW    14
`define PSPB_ST_ALL_EMPTY   7
`define PSPB_ST_UNDERFLOW   6

`define PSPB_PORT_LEGACY    2'h0
`define PSPB_PORT_ADDR      2'h1
`define PSPB_INCM_BUFFERED  2'h3
`define PSPB_IRQM_EVERY     2'h1
`define PSPB_IRQM_LAST      2'h3
`define PSPB_LAST_BUFFER    2'h3

`define PSPB_RST_WORD       16'h0000
`define PSPB_RST_FULL       4'h0
`define PSPB_RST_EMPTY      4'hF
`define PSPB_SYNC_W         13

`endif

// [rtl/pspb_sync.v]
// two-flop synchroniser for the slave pins
module pspb_sync
#(
   parameter W = 1
)
(
   input  wire         clk,
   input  wire         sys_rst,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);

   reg [W-1:0] stage1;

   // stage1 feeds only q, never any logic
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         stage1 <= {W{1'b0}};
         q      <= {W{1'b0}};
      end
      else
      begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule // pspb_sync

// [rtl/pspb_top.v]
// parallel slave port with legacy, buffered and addressable modes
//
// The address-and-strobe port and the placing of the registers were decided locally.
`include "pspb_map.vh"

module pspb_top
(
   input  wire                 clk,
   input  wire                 sys_rst,
   input  wire [`PSPB_AW-1:0]  reg_addr,
   input  wire [15:0]          reg_wdata,
   input  wire                 reg_wr,
   input  wire                 reg_rd,
   output reg  [15:0]          reg_rdata,
   input  wire                 chip_select_one,
   input  wire                 chip_select_two,
   input  wire                 read_strobe_in,
   input  wire                 write_strobe_in,
   input  wire [1:0]           buffer_select_inputs,
   input  wire [7:0]           parallel_data_in,
   output reg  [7:0]           parallel_data_out,
   output wire                 parallel_data_oe_n,
   output reg                  port_interrupt_flag
);

   // byte lane of a register pair, buffer 0 low byte of register one
   function [7:0] pick_byte;
      input [15:0] one;
      input [15:0] two;
      input [1:0]  idx;
      begin
         case (idx)
            2'h0:    pick_byte = one[7:0];
            2'h1:    pick_byte = one[15:8];
            2'h2:    pick_byte = two[7:0];
            default: pick_byte = two[15:8];
         endcase
      end
   endfunction

   // buffer chosen by an access: address pins or running pointer
   function [1:0] slot;
      input       addressed;
      input [1:0] pins;
      input [1:0] ptr;
      begin
         slot = addressed ? pins : ptr;
      end
   endfunction

   // software registers
   reg          module_enable;
   reg  [15:0]  port_mode_register;
   reg  [15:0]  output_register_one;
   reg  [15:0]  output_register_two;
   reg  [7:0]   in_byte [0:3];
   reg  [3:0]   input_byte_full;
   reg  [3:0]   output_byte_empty;
   reg          input_overflow_flag;
   reg          output_underflow_flag;

   // pin side state
   reg  [1:0]   rd_ptr;
   reg  [1:0]   wr_ptr;
   reg          rd_prev;
   reg          wr_prev;
   reg          en_prev;
   reg  [7:0]   wr_data_hold;
   reg  [1:0]   wr_slot_hold;
   reg  [1:0]   rd_slot_hold;
   reg          drive;

   wire [`PSPB_SYNC_W-1:0] pins_s;
   wire        cs_s;
   wire        rd_s;
   wire        wr_s;
   wire [1:0]  addr_s;
   wire [7:0]  data_s;

   // chip select two is a master-mode pin and never enters the slave
   pspb_sync #(.W(`PSPB_SYNC_W)) u_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({chip_select_one, read_strobe_in, write_strobe_in,
                 buffer_select_inputs, parallel_data_in}),
      .q       (pins_s)
   );

   // bit order follows the synchroniser input above
   assign cs_s   = pins_s[12];
   assign rd_s   = pins_s[11];
   assign wr_s   = pins_s[10];
   assign addr_s = pins_s[9:8];
   assign data_s = pins_s[7:0];

   wire [1:0] port_mode = port_mode_register[`PSPB_MODE_PORT_HI:
                                             `PSPB_MODE_PORT_LO];
   wire [1:0] incm      = port_mode_register[`PSPB_MODE_INCM_HI:
                                             `PSPB_MODE_INCM_LO];
   wire [1:0] irqm      = port_mode_register[`PSPB_MODE_IRQM_HI:
                                             `PSPB_MODE_IRQM_LO];

   wire mode_addr   = (port_mode == `PSPB_PORT_ADDR);
   wire mode_low    = (port_mode == `PSPB_PORT_LEGACY);
   wire slave_on    = module_enable & (mode_low | mode_addr);
   wire mode_buf    = mode_low & (incm == `PSPB_INCM_BUFFERED);
   wire mode_legacy = mode_low & ~mode_buf;

   // only chip select one qualifies the strobes
   wire rd_act   = slave_on & cs_s & rd_s;
   wire wr_act   = slave_on & cs_s & wr_s;
   wire rd_start = rd_act & ~rd_prev;
   wire rd_end   = rd_prev & ~rd_act;
   wire wr_start = wr_act & ~wr_prev;
   wire wr_end   = wr_prev & ~wr_act;

   // legacy uses byte 0 only; buffered walks pointers
   wire [1:0] rd_slot = mode_legacy ? 2'h0 :
                        slot(mode_addr, addr_s, rd_ptr);
   wire [1:0] wr_slot = mode_legacy ? 2'h0 :
                        slot(mode_addr, addr_s, wr_ptr);

   wire all_inputs_full   = mode_legacy ? input_byte_full[0] :
                            &input_byte_full;
   wire all_outputs_empty = mode_legacy ? output_byte_empty[0] :
                            &output_byte_empty;

   // interrupt decision for one strobe on a given buffer
   // both use the buffer held at access start: the read pointer
   // has already moved on by the time the read ends
   wire irq_rd = mode_legacy ? 1'b1 :
                 (irqm == `PSPB_IRQM_EVERY) |
                 ((irqm == `PSPB_IRQM_LAST) &
                  (rd_slot_hold == `PSPB_LAST_BUFFER));
   wire irq_wr = mode_legacy ? 1'b1 :
                 (irqm == `PSPB_IRQM_EVERY) |
                 ((irqm == `PSPB_IRQM_LAST) &
                  (wr_slot_hold == `PSPB_LAST_BUFFER));

   wire sw_wr_ctl  = reg_wr & (reg_addr == `PSPB_OFS_CONTROL);
   wire sw_wr_mode = reg_wr & (reg_addr == `PSPB_OFS_MODE);
   wire sw_wr_o1   = reg_wr & (reg_addr == `PSPB_OFS_OUT_ONE);
   wire sw_wr_o2   = reg_wr & (reg_addr == `PSPB_OFS_OUT_TWO);
   wire sw_wr_st   = reg_wr & (reg_addr == `PSPB_OFS_STATUS);
   wire sw_wr_irq  = reg_wr & (reg_addr == `PSPB_OFS_IRQ_FLAG);
   wire sw_rd_i1   = reg_rd & (reg_addr == `PSPB_OFS_IN_ONE);
   wire sw_rd_i2   = reg_rd & (reg_addr == `PSPB_OFS_IN_TWO);

   // a fresh enable restarts buffer control and status
   // the data bytes themselves survive a disable
   wire en_rise = module_enable & ~en_prev;

   assign parallel_data_oe_n = ~drive;

   // unimplemented status bits read as zero
   wire [15:0] status_word = {all_inputs_full, input_overflow_flag,
                              2'b00, input_byte_full,
                              all_outputs_empty, output_underflow_flag,
                              2'b00, output_byte_empty};

   // configuration registers
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         module_enable       <= 1'b0;
         port_mode_register  <= `PSPB_RST_WORD;
         output_register_one <= `PSPB_RST_WORD;
         output_register_two <= `PSPB_RST_WORD;
         en_prev             <= 1'b0;
      end
      else
      begin
         en_prev <= module_enable;
         if (sw_wr_ctl)
            module_enable <= reg_wdata[`PSPB_CTL_ENABLE];
         if (sw_wr_mode)
            port_mode_register <= {1'b0, reg_wdata[14:8], 8'h00};
         if (sw_wr_o1)
            output_register_one <= reg_wdata;
         if (sw_wr_o2)
            output_register_two <= reg_wdata;
      end
   end

   // pin access tracking and captured data
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         rd_prev           <= 1'b0;
         wr_prev           <= 1'b0;
         drive             <= 1'b0;
         wr_data_hold      <= 8'h00;
         wr_slot_hold      <= 2'h0;
         rd_slot_hold      <= 2'h0;
         parallel_data_out <= 8'h00;
      end
      else
      begin
         rd_prev <= rd_act;
         wr_prev <= wr_act;
         // latest data seen while the write strobe is still high
         // the master must hold the byte steady while wr is high
         if (wr_act)
            wr_data_hold <= data_s;
         if (wr_start)
            wr_slot_hold <= wr_slot;
         if (rd_start)
         begin
            parallel_data_out <= pick_byte(output_register_one,
                                           output_register_two,
                                           rd_slot);
            drive <= 1'b1;
            rd_slot_hold <= rd_slot;
         end
         // a disable mid read ends the access like a dropped strobe
         else if (~rd_act)
            drive <= 1'b0;
      end
   end

   // buffer flags, pointers and write capture
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         in_byte[0]            <= 8'h00;
         in_byte[1]            <= 8'h00;
         in_byte[2]            <= 8'h00;
         in_byte[3]            <= 8'h00;
         input_byte_full       <= `PSPB_RST_FULL;
         output_byte_empty     <= `PSPB_RST_EMPTY;
         input_overflow_flag   <= 1'b0;
         output_underflow_flag <= 1'b0;
         rd_ptr                <= 2'h0;
         wr_ptr                <= 2'h0;
         port_interrupt_flag   <= 1'b0;
      end
      else
      begin
         // software side first, so a same-cycle hardware set wins
         if (en_rise)
         begin
            input_byte_full       <= `PSPB_RST_FULL;
            output_byte_empty     <= `PSPB_RST_EMPTY;
            input_overflow_flag   <= 1'b0;
            output_underflow_flag <= 1'b0;
            rd_ptr                <= 2'h0;
            wr_ptr                <= 2'h0;
         end
         if (sw_rd_i1)
         begin
            input_byte_full[0] <= 1'b0;
            input_byte_full[1] <= 1'b0;
         end
         if (sw_rd_i2)
         begin
            input_byte_full[2] <= 1'b0;
            input_byte_full[3] <= 1'b0;
         end
         // legacy software writes leave the empty flag set
         if (sw_wr_o1 & ~mode_legacy)
         begin
            output_byte_empty[0] <= 1'b0;
            output_byte_empty[1] <= 1'b0;
         end
         if (sw_wr_o2 & ~mode_legacy)
         begin
            output_byte_empty[2] <= 1'b0;
            output_byte_empty[3] <= 1'b0;
         end
         // writing zero clears a sticky error bit
         if (sw_wr_st & ~reg_wdata[`PSPB_ST_OVERFLOW])
            input_overflow_flag <= 1'b0;
         if (sw_wr_st & ~reg_wdata[`PSPB_ST_UNDERFLOW])
            output_underflow_flag <= 1'b0;
         if (sw_wr_irq & reg_wdata[0])
            port_interrupt_flag <= 1'b0;

         // read strobe: byte leaves, buffer marked empty
         if (rd_start)
         begin
            if (output_byte_empty[rd_slot] & ~mode_legacy)
               output_underflow_flag <= 1'b1;
            output_byte_empty[rd_slot] <= 1'b1;
            if (mode_buf)
               rd_ptr <= rd_ptr + 2'h1;
         end
         if (rd_end & irq_rd)
            port_interrupt_flag <= 1'b1;

         // write ends: byte lands unless a buffered or addressed buffer is still full
         if (wr_end)
         begin
            if (input_byte_full[wr_slot_hold] & ~mode_legacy)
               input_overflow_flag <= 1'b1;
            else
            begin
               in_byte[wr_slot_hold] <= wr_data_hold;
               input_byte_full[wr_slot_hold] <= 1'b1;
            end
            // pointers wrap from buffer 3 back to 0
            if (mode_buf)
               wr_ptr <= wr_ptr + 2'h1;
            if (irq_wr)
               port_interrupt_flag <= 1'b1;
         end
      end
   end

   // read data one cycle after the strobe, zero when unmapped
   always @(posedge clk)
   begin
      if (sys_rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         case (reg_addr)
            `PSPB_OFS_CONTROL:
               reg_rdata <= {module_enable, 15'h0000};
            `PSPB_OFS_MODE:
               reg_rdata <= port_mode_register;
            `PSPB_OFS_OUT_ONE:
               reg_rdata <= output_register_one;
            `PSPB_OFS_OUT_TWO:
               reg_rdata <= output_register_two;
            `PSPB_OFS_IN_ONE:
               reg_rdata <= {in_byte[1], in_byte[0]};
            `PSPB_OFS_IN_TWO:
               reg_rdata <= {in_byte[3], in_byte[2]};
            `PSPB_OFS_STATUS:
               reg_rdata <= status_word;
            `PSPB_OFS_IRQ_FLAG:
               reg_rdata <= {15'h0000, port_interrupt_flag};
            default:
               reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

endmodule // pspb_top

// [tb/pspb_properties.sv]
// assertions and covers on the slave port pins and register bus
`include "pspb_map.vh"
module pspb_properties
(
   input wire                clk,
   input wire                sys_rst,
   input wire [`PSPB_AW-1:0] reg_addr,
   input wire [15:0]         reg_wdata,
   input wire                reg_wr,
   input wire                reg_rd,
   input wire [15:0]         reg_rdata,
   input wire                chip_select_one,
   input wire                read_strobe_in,
   input wire                write_strobe_in,
   input wire [7:0]          parallel_data_out,
   input wire                parallel_data_oe_n,
   input wire                port_interrupt_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   wire        rd_acc  = chip_select_one && read_strobe_in;
   wire        any_acc = rd_acc || (chip_select_one && write_strobe_in);
   wire        irq_clr = reg_wr && reg_addr == `PSPB_OFS_IRQ_FLAG
                         && reg_wdata[0];
   logic [2:0] idle;
   logic       st_rd;
   // an end event may land up to three edges after select drops
   always @(posedge clk)
      if (sys_rst || chip_select_one)
         idle <= 3'h0;
      else if (idle != 3'h7)
         idle <= idle + 3'h1;
   always @(posedge clk)
      st_rd <= !sys_rst && reg_rd && reg_addr == `PSPB_OFS_STATUS;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_oe_needs_read:
      assert property (!parallel_data_oe_n |-> $past(rd_acc, 3))
      else $error("data bus driven without a read access");
   chk_oe_held_read:
      assert property (!parallel_data_oe_n && rd_acc |=> !parallel_data_oe_n)
      else $error("data bus released during a read");
   chk_dout_on_read:
      assert property (!$stable(parallel_data_out) |-> !parallel_data_oe_n)
      else $error("output byte changed outside a read");
   chk_irq_after_end:
      assert property ($rose(port_interrupt_flag) |-> !$past(any_acc, 2))
      else $error("interrupt raised before access end");
   chk_irq_sticky:
      assert property (port_interrupt_flag && !irq_clr |=> port_interrupt_flag)
      else $error("interrupt flag dropped by itself");
   chk_irq_clear:
      assert property (irq_clr && idle > 3'h4 |=> !port_interrupt_flag)
      else $error("interrupt flag not cleared");
   chk_all_empty:
      assert property (st_rd && &reg_rdata[3:0] |-> reg_rdata[7])
      else $error("all outputs empty not set");
   chk_all_full:
      assert property (st_rd && &reg_rdata[11:8] |-> reg_rdata[15])
      else $error("all inputs full not set");
   cover property ($fell(parallel_data_oe_n));
   cover property ($rose(port_interrupt_flag));
   cover property (st_rd && reg_rdata[14]);
endmodule // pspb_properties

// [tb/pspb_master.sv]
// external bus master driving the slave port pins
module pspb_master
(
   input  wire        clk,
   output logic       cs1,
   output logic       cs2,
   output logic       rd,
   output logic       wr,
   output logic [1:0] a,
   output logic [7:0] d,
   input  wire  [7:0] q_in,
   input  wire        oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {cs1, cs2, rd, wr, a, d} = 0;
   end
   task xfer(input logic r, input logic [1:0] ad, input logic [7:0] dv,
             input logic two, output logic [7:0] q, output logic oe);
      @(posedge clk);
      cs1 <= !two;
      cs2 <= two;
      a <= ad;
      d <= dv;
      rd <= r;
      wr <= !r;
      // held five cycles, above the synchroniser minimum
      repeat (5) @(posedge clk);
      q = q_in;
      oe = oe_n;
      {cs1, cs2, rd, wr} <= 4'h0;
      // released bus shows the inverse so a stale byte cannot pass
      d <= ~dv;
      repeat (6) @(posedge clk);
   endtask
endmodule // pspb_master

// [tb/tb_top.sv]
// self-checking bench for the parallel slave port
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, oe;
   logic [2:0]  reg_addr = 0;
   logic [15:0] reg_wdata = 0;
   logic [7:0]  q;
   wire  [15:0] reg_rdata;
   wire         cs1, cs2, rd, wr, oe_n, irq;
   wire  [1:0]  ba;
   wire  [7:0]  md, dout, pin;
   int          errors = 0, n_tests = 0;
   always #50 clk = ~clk;
   assign pin = oe_n ? md : dout;
   pspb_top i_pspb_top(.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .chip_select_one(cs1), .chip_select_two(cs2),
      .read_strobe_in(rd), .write_strobe_in(wr), .buffer_select_inputs(ba),
      .parallel_data_in(pin), .parallel_data_out(dout),
      .parallel_data_oe_n(oe_n), .port_interrupt_flag(irq));
   pspb_master i_pspb_master(.clk(clk), .cs1(cs1), .cs2(cs2), .rd(rd),
      .wr(wr), .a(ba), .d(md), .q_in(pin), .oe_n(oe_n));
   task print_verdict;
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e)
      begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task wreg(input logic [2:0] ad, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1;
      reg_addr <= ad;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 0;
   endtask
   task rreg(input logic [2:0] ad, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1;
      reg_addr <= ad;
      @(posedge clk);
      reg_rd <= 0;
      @(posedge clk);
      chk(reg_rdata, e);
   endtask
   task pw(input logic [1:0] ad, input logic [7:0] v);
      i_pspb_master.xfer(0, ad, v, 0, q, oe);
   endtask
   task pr(input logic [1:0] ad);
      i_pspb_master.xfer(1, ad, 8'h00, 0, q, oe);
   endtask
   task setup(input logic [15:0] mode);
      wreg(0, 16'h0000);
      wreg(1, mode);
      wreg(0, 16'h8000);
      wreg(7, 16'h0001);
   endtask
   task t_refused;
      rreg(6, 16'h008F);
      pw(0, 8'h5A);
      rreg(6, 16'h008F);
      for (int m = 2; m < 4; m++)
      begin
         setup({6'h00, m[1:0], 8'h00});
         pw(0, 8'h5A);
         rreg(6, 16'h008F);
         chk(irq, 0);
      end
      setup(16'h0000);
      i_pspb_master.xfer(0, 0, 8'h5A, 1, q, oe);
      rreg(6, 16'h008F);
   endtask
   task t_legacy;
      pw(0, 8'hA5);
      chk(irq, 1);
      rreg(6, 16'h818F);
      rreg(4, 16'h00A5);
      wreg(7, 16'h0001);
      wreg(2, 16'h003C);
      rreg(6, 16'h008F);
      pr(0);
      chk({oe, q}, 9'h03C);
      chk({irq, oe_n}, 2'h3);
   endtask
   task t_buffered;
      setup(16'h3800);
      for (int i = 0; i < 4; i++)
      begin
         wreg(7, 16'h0001);
         pw(0, 8'h11 * (i + 1));
         chk(irq, 1);
      end
      rreg(6, 16'h8F8F);
      pw(0, 8'hEE);
      rreg(6, 16'hCF8F);
      wreg(6, 16'h0000);
      rreg(6, 16'h8F8F);
      rreg(4, 16'h2211);
      rreg(5, 16'h4433);
      wreg(2, 16'hBBAA);
      wreg(3, 16'hDDCC);
      rreg(6, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         pr(0);
         chk(q, 8'hAA + 8'h11 * i);
      end
      rreg(6, 16'h008F);
      pr(0);
      rreg(6, 16'h00CF);
      setup(16'h7800);
      for (int i = 0; i < 4; i++)
      begin
         pw(0, 8'h01);
         chk(irq, i == 3);
      end
      wreg(7, 16'h0001);
      for (int i = 0; i < 4; i++)
      begin
         pr(0);
         chk(irq, i == 3);
      end
      setup(16'h1800);
      pw(0, 8'h01);
      pr(0);
      chk(irq, 0);
   endtask
   task t_addressed;
      setup(16'h6100);
      pw(2, 8'h5A);
      chk(irq, 0);
      pw(3, 8'h77);
      chk(irq, 1);
      pw(2, 8'h66);
      rreg(6, 16'h4C8F);
      rreg(5, 16'h775A);
      wreg(2, 16'h9900);
      pr(1);
      chk(q, 8'h99);
      rreg(6, 16'h400E);
   endtask
   initial
   begin
      repeat (50000) @(posedge clk);
      errors++;
      print_verdict;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 0;
      repeat (2) @(posedge clk);
      t_refused;
      t_legacy;
      t_buffered;
      t_addressed;
      print_verdict;
   end
endmodule // tb_top
bind pspb_top pspb_properties i_pspb_properties(.clk(clk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .chip_select_one(chip_select_one), .read_strobe_in(read_strobe_in),
   .write_strobe_in(write_strobe_in), .parallel_data_out(parallel_data_out),
   .parallel_data_oe_n(parallel_data_oe_n),
   .port_interrupt_flag(port_interrupt_flag));
